// ==== test/prc_host_model.sv ====
/*
  Host processor model: drives the core enable pin and warm reset request.
  Assumes the bench commands it through level inputs set after clk rises.
*/
`timescale 1ns/1ns
module prc_host_model (
  input  wire logic       clk,        // System clock
  input  wire logic       reset,      // Sync reset, high
  input  wire logic       enWanted,   // Core converter wanted on
  input  wire logic       warmGo,     // Start a warm request
  input  wire logic [7:0] warmCycles, // Request length, cycles
  output logic            enPin,      // Core enable pin
  output logic            warmReq     // Warm reset request pin
);
  // =============================================
  // Pin drive
  logic [7:0] warmLeft_ff;
  always_ff @(posedge clk)
  begin
    if (reset)
      warmLeft_ff <= 8'h00;
    else if (warmGo)
      warmLeft_ff <= warmCycles;
    else if (warmLeft_ff != 8'h00)
      warmLeft_ff <= warmLeft_ff - 8'h01;
  end
  // Both pins are driven levels, never left floating
  assign enPin   = enWanted & ~reset;
  assign warmReq = (warmLeft_ff != 8'h00);
endmodule : prc_host_model

// ==== test/prc_reset_control_test.sv ====
/*
  Self-checking bench of the reset and enable control block, short counts.
  Assumes the host model is compiled first.
*/
`timescale 1ns/1ns
module prc_reset_control_test;
  // =============================================
  // Signals
  localparam int TCK = 4;
  localparam int DEF = 5;
  logic clk = 1'b0, reset = 1'b1, supplyUp = 1'b0, rtcRise = 1'b0, rtcFall = 1'b1;
  logic defSel = 1'b0, voltWr = 1'b0, enWanted = 1'b0, warmGo = 1'b0;
  logic [31:0] delayTicks = 32'h0;
  logic [15:0] voltData = 16'h0, coreOut;
  logic [7:0] warmCycles = 8'h0;
  logic enPin, warmReq, convEn, devOn, rstOe, rstN;
  int mismatches = 0, n_checks = 0, cycles = 0, waited;
  prc_reset_control #(.TICK_CYCLES(TCK), .DEBOUNCE_TICKS(2), .DELAY_TICKS(DEF)) i_dut (
    .clk(clk), .reset(reset), .supplyAboveLockout(supplyUp), .rtcAboveRise(rtcRise),
    .rtcBelowFall(rtcFall), .coreConvEnablePin(enPin), .warmResetRequest(warmReq),
    .coreDefaultSelect(defSel), .resetDelayTicks(delayTicks), .coreVoltWrite(voltWr),
    .coreVoltWriteData(voltData), .coreConverterEnable(convEn),
    .coreConverterOutput(coreOut), .deviceOn(devOn), .systemResetOutOe(rstOe),
    .systemResetOutN(rstN));
  prc_host_model i_host (.clk(clk), .reset(reset), .enWanted(enWanted), .warmGo(warmGo),
    .warmCycles(warmCycles), .enPin(enPin), .warmReq(warmReq));
  initial
  begin
    forever #4 clk = ~clk;
  end
  // Hang guard, well above the longest sequence
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      mismatches++;
      complete_run();
    end
  end
  // =============================================
  // Helpers
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wait_rst(input logic lvl);
    waited = 0;
    while (rstN !== lvl && waited < 400)
    begin
      cyc(1);
      waited++;
    end
  endtask : wait_rst
  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
    cyc(2);
  endtask : pulse
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : complete_run
  // =============================================
  // Scenarios
  task automatic t_power_up();
    chk({rstN, rstOe, devOn, convEn, coreOut}, 20'h404b0);
    enWanted = 1'b1;
    cyc(20);
    chk(convEn, 1'b0);
    supplyUp = 1'b1;
    cyc(30);
    chk({devOn, rstN, convEn}, 3'b101);
  endtask : t_power_up
  task automatic t_release(input logic [31:0] ticks, input int exp);
    delayTicks = ticks;
    rtcFall = 1'b0;
    cyc(8);
    chk(rstN, 1'b0);
    rtcRise = 1'b1;
    wait_rst(1'b1);
    chk(waited >= exp * TCK - TCK && waited <= exp * TCK + 2 * TCK, 1'b1);
    chk(rstOe, 1'b0);
    enWanted = 1'b0;
    cyc(3);
    chk(convEn, 1'b0);
    enWanted = 1'b1;
    cyc(3);
    chk(convEn, 1'b1);
  endtask : t_release
  task automatic t_warm();
    defSel = 1'b1;
    voltData = 16'h0a00;
    pulse(voltWr);
    chk(coreOut, 16'h0a00);
    warmCycles = 8'h02;
    pulse(warmGo);
    cyc(20);
    chk({rstN, coreOut}, 20'h10a00);
    warmCycles = 8'h3c;
    pulse(warmGo);
    chk(rstN, 1'b1);
    cyc(24);
    chk({rstN, rstOe, devOn, convEn, coreOut}, 20'h70640);
    pulse(voltWr);
    chk(coreOut, 16'h0640);
    wait_rst(1'b1);
    chk(rstN, 1'b1);
  endtask : t_warm
  task automatic t_drop_and_off();
    defSel = 1'b0;
    voltData = 16'h0900;
    pulse(voltWr);
    rtcFall = 1'b1;
    rtcRise = 1'b0;
    cyc(3);
    chk({rstN, coreOut}, 20'h004b0);
    t_release(32'h0a, 10);
    supplyUp = 1'b0;
    cyc(3);
    chk({devOn, convEn, rstN, rstOe, coreOut}, 20'h104b0);
  endtask : t_drop_and_off
  task automatic t_reset_again();
    reset = 1'b1;
    cyc(3);
    reset = 1'b0;
    cyc(2);
    chk({rstN, rstOe, devOn, convEn, coreOut}, 20'h404b0);
  endtask : t_reset_again
  initial
  begin
    cyc(10);
    reset = 1'b0;
    cyc(2);
    t_power_up();
    t_release(32'h0, DEF);
    t_warm();
    t_drop_and_off();
    t_reset_again();
    complete_run();
  end
endmodule : prc_reset_control_test

// ==== verilog/prc_debounce.sv ====
/*
  Debounce filter for one level input, advanced on a slow tick enable.
  Assumes the input is synchronous to clk.
*/
`timescale 1ns/1ns
module prc_debounce #(
  parameter int COUNT = 30000
) (
  input  wire logic clk,     // System clock
  input  wire logic reset,   // Sync reset, high
  input  wire logic tick,    // Timebase enable
  input  wire logic rawIn,   // Raw level
  output logic      cleanOut // Filtered level
);
  typedef struct packed {
    logic [31:0] cnt;
    logic        level;
  } prc_deb_type;

  prc_deb_type state_ff;
  prc_deb_type nxt_state;

  // =============================================================
  // Filter: output follows only after the input holds for COUNT ticks
  always_comb
  begin
    nxt_state = state_ff;
    if (rawIn == state_ff.level)
      nxt_state.cnt = 32'h0;
    else if (tick)
    begin
      if (state_ff.cnt >= 32'(COUNT - 1))
      begin
        nxt_state.level = rawIn;
        nxt_state.cnt   = 32'h0;
      end
      else
        nxt_state.cnt = state_ff.cnt + 32'h1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      state_ff <= '0;
    else
      state_ff <= nxt_state;
  end

  assign cleanOut = state_ff.level;
endmodule : prc_debounce

// ==== verilog/prc_map.svh ====
/*
  Constants for the reset and enable control block: timing figures and counts.
  Assumes a 125 MHz system clock.
*/
`ifndef PRC_MAP_SVH
`define PRC_MAP_SVH
// =============================================================
// Timing
`define PRC_CLK_MHZ          125
`define PRC_DEBOUNCE_MS      30
`define PRC_RESET_DELAY_MS   100
`define PRC_TICK_US          1
// Cycles per 1 us timebase tick
`define PRC_TICK_CYCLES      (`PRC_TICK_US * `PRC_CLK_MHZ)
// Debounce time in ticks (rounded down, us base)
`define PRC_DEBOUNCE_TICKS   (`PRC_DEBOUNCE_MS * 1000 / `PRC_TICK_US)
// Release delay in ticks for the nominal 1 nF capacitor
`define PRC_RESET_DELAY_TICKS (`PRC_RESET_DELAY_MS * 1000 / `PRC_TICK_US)
// =============================================================
// Core voltage codes, millivolts
`define PRC_CORE_LOW_MV      16'h04b0
`define PRC_CORE_HIGH_MV     16'h0640
`endif

// ==== verilog/prc_pkg.sv ====
/*
  Types for the reset and enable control block.
  Assumes nothing beyond the map header.
*/
package prc_pkg;
  typedef enum logic [1:0] {
    PWR_OFF,
    PWR_HOLD,
    PWR_DELAY,
    PWR_RUN
  } prc_mode_type;
endpackage : prc_pkg

// ==== verilog/prc_reset_control.sv ====
/*
  Reset and core converter enable control of a power-management device.
  Assumes comparator outputs and pins synchronous to clk; open-drain reset pin
  is resolved outside (driven low while its enable is high).
*/
`timescale 1ns/1ns
`include "prc_map.svh"

// Notes on behaviour
// - Core enable pin low disables, high enables
// - Warm reset request asserts system reset
// - Warm reset touches only core voltage
// - Warm reset reloads default core voltage
// - Warm reset request is debounced
// - Reset held low from power-up
// - Reset low while rtc low, then delay
// - Release delay is configurable count
// - OFF mode below lockout threshold
// - ON mode above lockout, converters available
// - Debounce lasts about 30 ms
// - Default select low 1.2V, high 1.6V
// - Core default also on lockout, rtc, reset
// - Delay counts after rtc above upper threshold
module prc_reset_control #(
  parameter int TICK_CYCLES    = `PRC_TICK_CYCLES,
  parameter int DEBOUNCE_TICKS = `PRC_DEBOUNCE_TICKS,
  parameter int DELAY_TICKS    = `PRC_RESET_DELAY_TICKS
) (
  input  wire logic        clk,                  // 125 MHz clock
  input  wire logic        reset,                // Sync reset, high
  input  wire logic        supplyAboveLockout,   // Main supply above lockout
  input  wire logic        rtcAboveRise,         // Rtc supply above 2.52 V
  input  wire logic        rtcBelowFall,         // Rtc supply below 2.4 V
  input  wire logic        coreConvEnablePin,    // Core converter enable pin
  input  wire logic        warmResetRequest,     // Warm reset request pin
  input  wire logic        coreDefaultSelect,    // Core default select pin
  input  wire logic [31:0] resetDelayTicks,      // Delay from cap pin, 0 = default
  input  wire logic        coreVoltWrite,        // Host voltage update strobe
  input  wire logic [15:0] coreVoltWriteData,    // New core voltage, mV
  output logic             coreConverterEnable,  // Core converter enable
  output logic [15:0]      coreConverterOutput,  // Core voltage setting, mV
  output logic             deviceOn,             // ON mode
  output logic             systemResetOutOe,     // Drives reset pin low
  output logic             systemResetOutN       // Reset level, low active
);
  typedef struct packed {
    prc_pkg::prc_mode_type mode;
    logic [31:0]           delayCnt;
    logic [31:0]           tickCnt;
    logic                  tick;
    logic                  resetN;
    logic                  enable;
    logic [15:0]           coreMv;
    logic [31:0]           reqRun;
  } prc_state_type;

  prc_state_type state_ff;
  prc_state_type nxt_state;
  logic          warmClean;
  logic [31:0]   delayTarget;

  function automatic logic [15:0] coreDefault(input logic sel);
    coreDefault = sel ? `PRC_CORE_HIGH_MV : `PRC_CORE_LOW_MV;
  endfunction : coreDefault

  // =============================================================
  // Warm reset filter
  prc_debounce #(
    .COUNT (DEBOUNCE_TICKS)
  ) u_deb (
    .clk      (clk),
    .reset    (reset),
    .tick     (state_ff.tick),
    .rawIn    (warmResetRequest),
    .cleanOut (warmClean)
  );

  // Cap pin has no value yet on a bare bench, so zero falls back
  assign delayTarget = (resetDelayTicks == 32'h0) ? 32'(DELAY_TICKS)
                                                  : resetDelayTicks;

  // =============================================================
  // Sequencer
  always_comb
  begin
    nxt_state = state_ff;
    nxt_state.tick = 1'b0;
    if (state_ff.tickCnt >= 32'(TICK_CYCLES - 1))
    begin
      nxt_state.tickCnt = 32'h0;
      nxt_state.tick    = 1'b1;
    end
    else
      nxt_state.tickCnt = state_ff.tickCnt + 32'h1;

    // Run length of the raw request, read only by the debounce check
    if (!warmResetRequest)
      nxt_state.reqRun = 32'h0;
    else if (state_ff.reqRun != 32'hffffffff)
      nxt_state.reqRun = state_ff.reqRun + 32'h1;

    // Mode flow: OFF until the main supply clears lockout, then HOLD with
    // reset asserted. HOLD waits for the rtc rise comparator and a quiet
    // filtered request, DELAY counts timebase ticks up to the target, and
    // RUN releases the reset pin. Any rtc collapse or filtered request
    // drops back to HOLD, so the full release delay is served again.
    // Lockout loss wins over everything and lands in OFF.
    // Trade-off: the delay counter runs on the shared 1 us tick, so the
    // release time is quantised to one tick.
    case (state_ff.mode)
      prc_pkg::PWR_OFF:
      begin
        nxt_state.resetN   = 1'b0;
        nxt_state.delayCnt = 32'h0;
        if (supplyAboveLockout)
          nxt_state.mode = prc_pkg::PWR_HOLD;
      end
      prc_pkg::PWR_HOLD:
      begin
        nxt_state.resetN   = 1'b0;
        nxt_state.delayCnt = 32'h0;
        if (rtcAboveRise && !warmClean)
          nxt_state.mode = prc_pkg::PWR_DELAY;
      end
      prc_pkg::PWR_DELAY:
      begin
        nxt_state.resetN = 1'b0;
        if (state_ff.tick)
          nxt_state.delayCnt = state_ff.delayCnt + 32'h1;
        if (state_ff.delayCnt >= delayTarget)
        begin
          nxt_state.mode   = prc_pkg::PWR_RUN;
          nxt_state.resetN = 1'b1;
        end
      end
      prc_pkg::PWR_RUN:
        nxt_state.resetN = 1'b1;
      default:
        nxt_state.mode = prc_pkg::PWR_OFF;
    endcase

    // Rtc collapse or warm request restarts the hold from the top
    if (state_ff.mode != prc_pkg::PWR_OFF && (rtcBelowFall || warmClean))
    begin
      nxt_state.mode   = prc_pkg::PWR_HOLD;
      nxt_state.resetN = 1'b0;
    end
    if (!supplyAboveLockout)
    begin
      nxt_state.mode   = prc_pkg::PWR_OFF;
      nxt_state.resetN = 1'b0;
    end

    nxt_state.enable = coreConvEnablePin && (nxt_state.mode != prc_pkg::PWR_OFF);

    // Only the core setting is reloaded; nothing else is touched here
    if (!supplyAboveLockout || rtcBelowFall || warmClean || !state_ff.resetN)
      nxt_state.coreMv = coreDefault(coreDefaultSelect);
    else if (coreVoltWrite)
      nxt_state.coreMv = coreVoltWriteData;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state_ff        <= '0;
      state_ff.mode   <= prc_pkg::PWR_OFF;
      state_ff.resetN <= 1'b0;
      state_ff.coreMv <= `PRC_CORE_LOW_MV;
    end
    else
      state_ff <= nxt_state;
  end

  assign coreConverterEnable = state_ff.enable;
  assign coreConverterOutput = state_ff.coreMv;
  assign deviceOn            = (state_ff.mode != prc_pkg::PWR_OFF);
  assign systemResetOutN     = state_ff.resetN;
  assign systemResetOutOe    = !state_ff.resetN;

  // =============================================================
  // Checks
  a_off_holds_reset: assert property (@(posedge clk) disable iff (reset)
    !supplyAboveLockout |=> !systemResetOutN && !coreConverterEnable)
    else $error("reset or enable active in off mode");
  a_rtc_low_reset: assert property (@(posedge clk) disable iff (reset)
    rtcBelowFall |=> !systemResetOutN)
    else $error("reset released while rtc low");
  a_warm_reset: assert property (@(posedge clk) disable iff (reset)
    $rose(warmClean) |=> !systemResetOutN)
    else $error("warm request did not assert reset");
  a_warm_default: assert property (@(posedge clk) disable iff (reset)
    warmClean |=> coreConverterOutput == coreDefault($past(coreDefaultSelect)))
    else $error("core voltage not default after warm request");
  a_release_delay: assert property (@(posedge clk) disable iff (reset)
    $rose(systemResetOutN) |-> $past(state_ff.mode) == prc_pkg::PWR_DELAY)
    else $error("reset released without delay");
  a_enable_follow: assert property (@(posedge clk) disable iff (reset)
    supplyAboveLockout && !coreConvEnablePin |=> !coreConverterEnable)
    else $error("core enabled while pin low");
  a_on_mode: assert property (@(posedge clk) disable iff (reset)
    supplyAboveLockout [*2] |-> deviceOn)
    else $error("not on above lockout");
  a_off_mode: assert property (@(posedge clk) disable iff (reset)
    !supplyAboveLockout |=> !deviceOn)
    else $error("on below lockout");
  a_reset_default: assert property (@(posedge clk) disable iff (reset)
    !systemResetOutN && !coreVoltWrite |=> coreConverterOutput == coreDefault($past(coreDefaultSelect)))
    else $error("core voltage changed during reset");
  a_oe_pair: assert property (@(posedge clk) disable iff (reset)
    systemResetOutOe == !systemResetOutN)
    else $error("reset pin enable mismatch");

  // =============================================================
  // Further checks on sequencing, core setting and filter length
  // Most state what the next cycle must show for a given input mix; a_debounce_raw, a_debounce_len and a_off_reset_low check the same cycle

  a_delay_needs_rtc: assert property (@(posedge clk) disable iff (reset)
    state_ff.mode == prc_pkg::PWR_HOLD && !rtcAboveRise |=> state_ff.mode != prc_pkg::PWR_DELAY)
    else $error("delay started before rtc rise");

  a_warm_hold: assert property (@(posedge clk) disable iff (reset)
    warmClean && supplyAboveLockout |=> state_ff.mode == prc_pkg::PWR_HOLD)
    else $error("warm request did not return to hold");

  a_run_keeps: assert property (@(posedge clk) disable iff (reset)
    state_ff.mode == prc_pkg::PWR_RUN && supplyAboveLockout && !rtcBelowFall && !warmClean
    |=> systemResetOutN)
    else $error("reset dropped without cause");

  a_write_lands: assert property (@(posedge clk) disable iff (reset)
    systemResetOutN && supplyAboveLockout && !rtcBelowFall && !warmClean && coreVoltWrite
    |=> coreConverterOutput == $past(coreVoltWriteData))
    else $error("core voltage write lost");

  a_core_hold: assert property (@(posedge clk) disable iff (reset)
    systemResetOutN && supplyAboveLockout && !rtcBelowFall && !warmClean && !coreVoltWrite
    |=> $stable(coreConverterOutput))
    else $error("core voltage changed without cause");

  a_lockout_default: assert property (@(posedge clk) disable iff (reset)
    !supplyAboveLockout |=> coreConverterOutput == coreDefault($past(coreDefaultSelect)))
    else $error("core voltage not default under lockout");

  a_rtc_default: assert property (@(posedge clk) disable iff (reset)
    rtcBelowFall |=> coreConverterOutput == coreDefault($past(coreDefaultSelect)))
    else $error("core voltage not default with rtc low");

  a_write_refused: assert property (@(posedge clk) disable iff (reset)
    !systemResetOutN && coreVoltWrite |=> coreConverterOutput == coreDefault($past(coreDefaultSelect)))
    else $error("core voltage write taken during reset");

  a_off_reset_low: assert property (@(posedge clk) disable iff (reset)
    !deviceOn |-> !systemResetOutN)
    else $error("reset released in off mode");

  a_enable_on: assert property (@(posedge clk) disable iff (reset)
    supplyAboveLockout && coreConvEnablePin |=> coreConverterEnable)
    else $error("core not enabled while pin high");

  a_enable_off: assert property (@(posedge clk) disable iff (reset)
    !coreConvEnablePin |=> !coreConverterEnable)
    else $error("core enabled with pin low");

  a_debounce_raw: assert property (@(posedge clk) disable iff (reset)
    $rose(warmClean) |-> $past(warmResetRequest))
    else $error("filtered request without raw request");

  a_debounce_len: assert property (@(posedge clk) disable iff (reset)
    $rose(warmClean) |-> state_ff.reqRun >= 32'((DEBOUNCE_TICKS - 1) * TICK_CYCLES))
    else $error("warm request passed filter too early");

  a_hold_no_release: assert property (@(posedge clk) disable iff (reset)
    state_ff.mode == prc_pkg::PWR_HOLD |=> !systemResetOutN)
    else $error("reset released from hold");

  a_delay_low: assert property (@(posedge clk) disable iff (reset)
    state_ff.mode == prc_pkg::PWR_DELAY && state_ff.delayCnt < delayTarget |=> !systemResetOutN)
    else $error("reset released before delay elapsed");

  a_on_exit_off: assert property (@(posedge clk) disable iff (reset)
    state_ff.mode == prc_pkg::PWR_OFF && supplyAboveLockout |=> deviceOn)
    else $error("off mode kept above lockout");

  a_rtc_hold_mode: assert property (@(posedge clk) disable iff (reset)
    rtcBelowFall && deviceOn && supplyAboveLockout |=> state_ff.mode == prc_pkg::PWR_HOLD)
    else $error("rtc low did not return to hold");
endmodule : prc_reset_control
